// [src/sxd_pkg.sv]
package sxd_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSN_W = 14;

  // opcode fields
  localparam logic [1:0] TOP_FILE_OPS   = 2'h0;
  localparam logic [3:0] OPC_SWAP       = 4'hE;
  localparam logic [3:0] OPC_XOR_FILE   = 4'h6;
  localparam logic [9:0] OPC_DIR_LOAD   = 10'h006;
  localparam logic [5:0] OPC_XOR_LIT    = 6'h3A;   // 11 1010 kkkk kkkk
  localparam int         DEST_BIT       = 7;

  // port direction file addresses, reachable by plain file access too
  localparam logic [2:0] DIR_SEL_MIN    = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX    = 3'h7;
  localparam logic [6:0] DIR_FILE_BASE  = 7'h40;      // direction block in file space
  localparam int         NUM_DIR        = 3;

  localparam logic [7:0] DIR_RESET      = 8'hFF;     // all pins input after reset
  localparam logic [7:0] ACC_RESET      = 8'h00;

  typedef enum logic [2:0] {
    SXD_OP_NONE,
    SXD_OP_SWAP,
    SXD_OP_DIR_LOAD,
    SXD_OP_XOR_LIT,
    SXD_OP_XOR_FILE
  } sxd_op_t;

  // one fetched instruction
  typedef struct packed {
    logic              valid;
    logic [INSN_W-1:0] word;
  } sxd_insn_t;

  // write back to the file register space
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sxd_fwr_t;

endpackage : sxd_pkg

// [src/sxd_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module sxd_decode (
  input  wire  sxd_pkg::sxd_insn_t       insn,
  output var   sxd_pkg::sxd_op_t         op,
  output logic                           dest_file,
  output logic [sxd_pkg::ADDR_W-1:0]     faddr,
  output logic [sxd_pkg::DATA_W-1:0]     literal,
  output logic [2:0]                     dir_sel
);
  import sxd_pkg::*;

  // pure decode; instructions outside this group give none
  always_comb begin
    op        = SXD_OP_NONE;
    dest_file = insn.word[DEST_BIT];
    faddr     = insn.word[ADDR_W-1:0];
    literal   = insn.word[DATA_W-1:0];
    dir_sel   = insn.word[2:0];
    if (insn.valid) begin
      if (insn.word[13:12] == TOP_FILE_OPS && insn.word[11:8] == OPC_SWAP) begin
        op = SXD_OP_SWAP;
      end else if (insn.word[13:12] == TOP_FILE_OPS && insn.word[11:8] == OPC_XOR_FILE) begin
        op = SXD_OP_XOR_FILE;
      end else if (insn.word[13:4] == OPC_DIR_LOAD && insn.word[3] == 1'b0
                   && insn.word[2:0] >= DIR_SEL_MIN && insn.word[2:0] <= DIR_SEL_MAX) begin
        op = SXD_OP_DIR_LOAD;
      end else if (insn.word[13:8] == OPC_XOR_LIT) begin
        op = SXD_OP_XOR_LIT;
      end
    end
  end

endmodule : sxd_decode
`default_nettype wire

// [src/sxd_exec.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - nibble swap exchanges the file nibbles, no status flag changes
// - swap opcode is 00 1110 d fffffff; d=0 accumulator, d=1 file
// - 00 0000 0110 0fff copies accumulator to direction register 5..7, flags kept
// - direction registers also read and written through ordinary file addresses
// - literal xor: accumulator xor eight-bit literal into accumulator, zero flag only
// - 00 0110 d fffffff xors accumulator and file, d picks destination, zero flag only
module sxd_exec (
  input  wire  logic                         core_clk,
  input  wire  logic                         rst,
  input  wire  sxd_pkg::sxd_insn_t           insn,
  input  wire  logic [sxd_pkg::DATA_W-1:0]   file_rdata,
  input  wire  sxd_pkg::sxd_fwr_t            sw_dir_wr,
  output logic [sxd_pkg::ADDR_W-1:0]         file_raddr,
  output var   sxd_pkg::sxd_fwr_t            file_wr,
  output logic [sxd_pkg::DATA_W-1:0]         acc,
  output logic                               zero_flag,
  output logic                               zero_we,
  output logic [3*sxd_pkg::DATA_W-1:0]       dir_regs,
  output logic [sxd_pkg::DATA_W-1:0]         dir_rdata
);
  import sxd_pkg::*;

  sxd_op_t           op;
  logic              dest_file;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] literal;
  logic [2:0]        dir_sel;
  logic [DATA_W-1:0] acc_q;
  logic              zero_q;
  logic              zero_we_q;
  sxd_fwr_t          file_wr_q;
  logic [DATA_W-1:0] dir_q [NUM_DIR];
  logic [DATA_W-1:0] dir_rdata_q;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] file_val;

  sxd_decode u_dec (
    .insn      (insn),
    .op        (op),
    .dest_file (dest_file),
    .faddr     (faddr),
    .literal   (literal),
    .dir_sel   (dir_sel)
  );

  // map a file address onto a direction register slot; used for read and write
  function automatic logic dir_hit(input logic [ADDR_W-1:0] a);
    return a >= DIR_FILE_BASE && a < DIR_FILE_BASE + 7'(NUM_DIR);
  endfunction : dir_hit

  function automatic logic [1:0] dir_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - DIR_FILE_BASE;
    return d[1:0];
  endfunction : dir_idx

  // direction registers read like any other file location
  assign file_raddr = faddr;
  assign file_val   = dir_hit(faddr) ? dir_q[dir_idx(faddr)] : file_rdata;

  // combinational result: the whole operation fits one cycle
  always_comb begin
    unique case (op)
      SXD_OP_SWAP:     result = {file_val[3:0], file_val[7:4]};
      SXD_OP_XOR_LIT:  result = acc_q ^ literal;
      SXD_OP_XOR_FILE: result = acc_q ^ file_val;
      default:         result = acc_q;
    endcase
  end

  // accumulator write back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RESET;
    end else if (op == SXD_OP_XOR_LIT) begin
      acc_q <= result;
    end else if ((op == SXD_OP_SWAP || op == SXD_OP_XOR_FILE) && !dest_file) begin
      acc_q <= result;
    end
  end

  // zero flag: only the two xor forms touch it; swap and direction load leave it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zero_q    <= 1'b0;
      zero_we_q <= 1'b0;
    end else begin
      zero_we_q <= (op == SXD_OP_XOR_LIT || op == SXD_OP_XOR_FILE);
      if (op == SXD_OP_XOR_LIT || op == SXD_OP_XOR_FILE) begin
        zero_q <= (result == 8'h00);
      end
    end
  end

  // file write back, direction addresses excluded since they live here
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      file_wr_q <= '0;
    end else begin
      file_wr_q.we   <= (op == SXD_OP_SWAP || op == SXD_OP_XOR_FILE) && dest_file
                        && !dir_hit(faddr);
      file_wr_q.addr <= faddr;
      file_wr_q.data <= result;
    end
  end

  // direction registers: legacy load, instruction write back, or software file write
  for (genvar i = 0; i < NUM_DIR; i++) begin : g_dir
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        dir_q[i] <= DIR_RESET;
      end else if (op == SXD_OP_DIR_LOAD && dir_sel == DIR_SEL_MIN + 3'(i)) begin
        dir_q[i] <= acc_q;
      end else if ((op == SXD_OP_SWAP || op == SXD_OP_XOR_FILE) && dest_file
                   && dir_hit(faddr) && dir_idx(faddr) == 2'(i)) begin
        dir_q[i] <= result;
      end else if (sw_dir_wr.we && dir_hit(sw_dir_wr.addr) && dir_idx(sw_dir_wr.addr) == 2'(i)) begin
        dir_q[i] <= sw_dir_wr.data;
      end
    end
    assign dir_regs[i*DATA_W +: DATA_W] = dir_q[i];
  end

  // registered read port for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_rdata_q <= 8'h00;
    end else begin
      dir_rdata_q <= dir_hit(sw_dir_wr.addr) ? dir_q[dir_idx(sw_dir_wr.addr)] : 8'h00;
    end
  end

  assign acc       = acc_q;
  assign zero_flag = zero_q;
  assign zero_we   = zero_we_q;
  assign file_wr   = file_wr_q;
  assign dir_rdata = dir_rdata_q;

  // assertions
  property p_swap;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_SWAP && !dest_file) |=> acc_q == {$past(file_val[3:0]), $past(file_val[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");

  property p_swap_flags;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_SWAP || op == SXD_OP_DIR_LOAD) |=> !zero_we_q && $stable(zero_q);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("flag changed");

  property p_swap_file;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_SWAP && dest_file && !dir_hit(faddr)) |=> file_wr_q.we && $stable(acc_q);
  endproperty
  a_swap_file: assert property (p_swap_file) else $error("swap file write missing");

  property p_dir_load;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_DIR_LOAD && dir_sel == DIR_SEL_MAX) |=> dir_q[2] == $past(acc_q);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

  property p_dir_file;
    @(posedge core_clk) disable iff (rst)
    (sw_dir_wr.we && sw_dir_wr.addr == DIR_FILE_BASE && op == SXD_OP_NONE) |=> dir_q[0] == $past(sw_dir_wr.data);
  endproperty
  a_dir_file: assert property (p_dir_file) else $error("direction file write lost");

  property p_xor_lit;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_XOR_LIT) |=> acc_q == ($past(acc_q) ^ $past(literal)) && zero_we_q;
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong");

  property p_xor_file;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_XOR_FILE && dest_file && !dir_hit(faddr)) |=>
      file_wr_q.data == ($past(acc_q) ^ $past(file_val)) && $stable(acc_q);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file xor wrong");

  property p_zero;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_XOR_LIT || op == SXD_OP_XOR_FILE) |=> zero_q == ($past(result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // xor into the accumulator must leave the file side untouched
  property p_xor_file_acc;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_XOR_FILE && !dest_file) |=> acc_q == ($past(acc_q) ^ $past(file_val)) && !file_wr_q.we;
  endproperty
  a_xor_file_acc: assert property (p_xor_file_acc) else $error("file xor into accumulator wrong");

  property p_xor_lit_file;
    @(posedge core_clk) disable iff (rst)
    (op == SXD_OP_XOR_LIT) |=> !file_wr_q.we;
  endproperty
  a_xor_lit_file: assert property (p_xor_lit_file) else $error("literal xor wrote the file");

  // a write into the direction block stays here; a stray file write would alias plain ram
  property p_dir_write;
    @(posedge core_clk) disable iff (rst)
    ((op == SXD_OP_SWAP || op == SXD_OP_XOR_FILE) && dest_file && dir_hit(faddr)) |=>
      !file_wr_q.we && $stable(acc_q);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write leaked to file");

  // refused operands must leave every direction register alone
  property p_dir_refuse;
    @(posedge core_clk) disable iff (rst)
    (insn.valid && insn.word[13:4] == OPC_DIR_LOAD && op == SXD_OP_NONE && !sw_dir_wr.we) |=>
      $stable(dir_regs);
  endproperty
  a_dir_refuse: assert property (p_dir_refuse) else $error("refused direction load acted");

  // zero_we is a one-cycle strobe owned by the two xor forms only
  property p_zero_we_pulse;
    @(posedge core_clk) disable iff (rst)
    !(op == SXD_OP_XOR_LIT || op == SXD_OP_XOR_FILE) |=> !zero_we_q;
  endproperty
  a_zero_we_pulse: assert property (p_zero_we_pulse) else $error("zero update strobe stuck");

endmodule : sxd_exec
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sxd_pkg::*;
  logic                      core_clk;
  logic                      rst;
  sxd_insn_t                 insn;
  logic [DATA_W-1:0]         file_rdata;
  sxd_fwr_t                  sw_dir_wr;
  logic [ADDR_W-1:0]         file_raddr;
  sxd_fwr_t                  file_wr;
  logic [DATA_W-1:0]         acc;
  logic                      zero_flag;
  logic                      zero_we;
  logic [3*DATA_W-1:0]       dir_regs;
  logic [DATA_W-1:0]         dir_rdata;
  int                        mismatches;
  int                        tests_run;

  sxd_exec sxd_exec_i (.core_clk(core_clk), .rst(rst), .insn(insn), .file_rdata(file_rdata),
    .sw_dir_wr(sw_dir_wr), .file_raddr(file_raddr), .file_wr(file_wr), .acc(acc),
    .zero_flag(zero_flag), .zero_we(zero_we), .dir_regs(dir_regs), .dir_rdata(dir_rdata));

  // free-running 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_word

  // one instruction per call; valid is left high so calls may run back to back
  task automatic step(input logic [13:0] w, input logic [7:0] rd);
    insn = '{valid: 1'b1, word: w};
    file_rdata = rd;
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic idle();
    insn.valid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : idle

  task automatic t_xor_lit();
    step({OPC_XOR_LIT, 8'hA5}, 8'h00);
    chk_byte(acc, 8'hA5);
    chk_bit(zero_flag, 1'b0);
    chk_bit(zero_we, 1'b1);
    step({OPC_XOR_LIT, 8'hA5}, 8'h00);
    chk_byte(acc, 8'h00);
    chk_bit(zero_flag, 1'b1);
    idle();
    chk_bit(zero_we, 1'b0);
    $display("test xor literal done");
  endtask : t_xor_lit

  task automatic t_swap();
    step({2'h0, OPC_SWAP, 1'b0, 7'h20}, 8'hA5);
    chk_byte({1'b0, file_raddr}, 8'h20);
    chk_byte(acc, 8'h5A);
    chk_bit(zero_we, 1'b0);
    chk_bit(zero_flag, 1'b1);
    chk_bit(file_wr.we, 1'b0);
    step({2'h0, OPC_SWAP, 1'b1, 7'h20}, 8'hC3);
    chk_bit(file_wr.we, 1'b1);
    chk_byte({1'b0, file_wr.addr}, 8'h20);
    chk_byte(file_wr.data, 8'h3C);
    chk_byte(acc, 8'h5A);
    $display("test swap done");
  endtask : t_swap

  task automatic t_xor_file();
    step({2'h0, OPC_XOR_FILE, 1'b1, 7'h11}, 8'h0F);
    chk_bit(file_wr.we, 1'b1);
    chk_byte(file_wr.data, 8'h55);
    chk_byte(acc, 8'h5A);
    chk_bit(zero_flag, 1'b0);
    chk_bit(zero_we, 1'b1);
    step({2'h0, OPC_XOR_FILE, 1'b0, 7'h11}, 8'h5A);
    chk_byte(acc, 8'h00);
    chk_bit(zero_flag, 1'b1);
    chk_bit(file_wr.we, 1'b0);
    step({OPC_XOR_LIT, 8'h3C}, 8'h00);
    chk_byte(acc, 8'h3C);
    chk_bit(zero_flag, 1'b0);
    idle();
    $display("test xor file done");
  endtask : t_xor_file

  task automatic t_dir();
    step({OPC_DIR_LOAD, 4'h6}, 8'h00);
    chk_word(dir_regs, 24'hFF3CFF);
    chk_bit(zero_we, 1'b0);
    step({OPC_DIR_LOAD, 4'h4}, 8'h00);
    step({OPC_DIR_LOAD, 4'hD}, 8'h00);
    chk_word(dir_regs, 24'hFF3CFF);
    idle();
    sw_dir_wr = '{we: 1'b1, addr: 7'h42, data: 8'h33};
    @(posedge core_clk);
    #1;
    sw_dir_wr.we = 1'b0;
    @(posedge core_clk);
    #1;
    chk_word(dir_regs, 24'h333CFF);
    chk_byte(dir_rdata, 8'h33);
    $display("test direction done");
  endtask : t_dir

  // instruction access to the direction block lands in dir_regs, never on file_wr
  task automatic t_dir_file();
    step({2'h0, OPC_SWAP, 1'b1, 7'h41}, 8'h00);
    chk_word(dir_regs, 24'h33C3FF);
    chk_bit(file_wr.we, 1'b0);
    chk_byte(acc, 8'h3C);
    step({2'h0, OPC_XOR_FILE, 1'b0, 7'h40}, 8'h00);
    chk_byte({1'b0, file_raddr}, 8'h40);
    chk_byte(acc, 8'hC3);
    chk_bit(zero_flag, 1'b0);
    step({OPC_DIR_LOAD, 4'h7}, 8'h00);
    chk_word(dir_regs, 24'hC3C3FF);
    idle();
    sw_dir_wr = '{we: 1'b1, addr: 7'h40, data: 8'h5A};
    @(posedge core_clk);
    #1;
    sw_dir_wr.we = 1'b0;
    @(posedge core_clk);
    #1;
    chk_word(dir_regs, 24'hC3C35A);
    chk_byte(dir_rdata, 8'h5A);
    $display("test direction file access done");
  endtask : t_dir_file

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // watchdog: the tests need well under a hundred cycles
  initial begin
    #10000;
    mismatches++;
    summarize();
  end

  initial begin
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    insn = '0;
    file_rdata = 8'h00;
    sw_dir_wr = '0;
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk_byte(acc, ACC_RESET);
    chk_word(dir_regs, 24'hFFFFFF);
    chk_byte(dir_rdata, 8'h00);
    chk_bit(file_wr.we, 1'b0);
    chk_bit(zero_flag, 1'b0);
    chk_bit(zero_we, 1'b0);
    t_xor_lit();
    t_swap();
    t_xor_file();
    t_dir();
    t_dir_file();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
